// File: smbus_timing_ctrl.sv
// serial bus timing, timeout and byte engine with transmit fifo
//
// Overview of operation
// [R1] slaves may stretch scl low; master times high phase only after scl seen high
// [R2] scl timeout enabled: timer 2 reloads while scl high, counts while low
// [R3] software sets timer 2 to 25 ms and resets interface on overflow
// [R4] scl low beyond 25 ms is a timeout; reset communication within 10 ms
// [R5] bus free when scl and sda stay high over 10 bit-clock periods
// [R6] pending master start is issued right after the bus-free timeout
// [R7] bus-free timeout acts as a stop: interrupt flag and halt flag set
// [R8] software keeps a bit-clock source running when free timeout is used
// [R9] interrupt per byte; after ack when sending, before ack when receiving
// [R10] interrupt after master start generated and after slave sees stop
// [R11] enable bit turns on all master and slave handling
// [R12] slave events blocked: keep monitoring, nack addresses, no slave interrupts
// [R13] slave block takes effect from next start only
// [R14] clock select 0..3 picks timer0, timer1, timer2 high, timer2 low overflow
// [R15] bit-clock tick used only as master or with free timeout enabled
// [R16] master scl low and high phases each last at least one tick
// [R17] unhindered master bit takes three ticks, high twice the low
// [R18] shared bit-clock timer must be left running by software
// [R19] extension set: sda setup 11 clocks, hold 12 clocks
// [R20] extension clear: hold 3 clocks, setup low time or one clock
// [R21] software delay runs from data or ack write to flag clear
// [R22] software sets extension above 10 MHz for 250 ns and 300 ns
// [R23] interrupt flag set stalls the transfer with scl held low
// [R24] disable returns to idle and releases scl and sda
`timescale 1ns/1ps

module smbus_tx_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             push;
	logic             pop;

	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_valid_o = (count_q != '0);
	assign out_data_o  = mem_q[rd_q];

	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q       <= '0;
			rd_q       <= '0;
			count_q    <= '0;
			in_ready_o <= 1'b0;
		end else begin
			count_q    <= count_d;
			in_ready_o <= (count_d != DEPTH[AW:0]);
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module smbus_timing_ctrl
	import smbus_timing_pkg::*;
(
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RESET_N_I,
	// configuration and timer overflow ticks
	input  wire cfg_type           CFG_I,
	input  wire tick_type          TICK_I,
	// software control
	input  wire logic              START_REQ_I,
	input  wire logic              STOP_REQ_I,
	input  wire logic              INT_CLEAR_I,
	input  wire logic              ACK_VALUE_I,
	// transmit byte stream
	input  wire logic              TX_VALID_I,
	output logic                   TX_READY_O,
	input  wire logic [BYTE_W-1:0] TX_DATA_I,
	// received bytes
	output logic                   RX_VALID_O,
	output logic [BYTE_W-1:0]      RX_DATA_O,
	// status
	output logic                   IRQ_FLAG_O,
	output status_type             STATUS_O,
	output logic                   TIMER2_RELOAD_O,
	output logic                   TIMER2_COUNT_O,
	// open-drain bus pins
	input  wire logic              SCL_I,
	output logic                   SCL_O,
	output logic                   SCL_OE_O,
	input  wire logic              SDA_I,
	output logic                   SDA_O,
	output logic                   SDA_OE_O
);
	logic [1:0]        rst_sync_q;
	logic              rst_n;
	logic [1:0]        scl_sync_q;
	logic [1:0]        sda_sync_q;
	logic              scl_prev_q;
	logic              sda_prev_q;
	logic              scl_s;
	logic              sda_s;
	logic              scl_fall;
	logic              start_seen;
	logic              stop_seen;
	logic              sel_ovf;
	logic              tick;
	logic              free_ev;
	logic [3:0]        free_cnt_q;
	state_type         state_q;
	logic [3:0]        bit_q;
	logic [BYTE_W-1:0] shift_q;
	logic [7:0]        clk_cnt_q;
	logic [1:0]        tick_cnt_q;
	logic              sampled_q;
	logic              master_q;
	logic              tx_mode_q;
	logic              addr_q;
	logic              rw_q;
	logic              blocked_q;
	logic              ignore_q;
	logic              ack_q;
	logic              irq_q;
	logic              halt_q;
	logic              arb_q;
	logic              ack_rx_q;
	logic              busy_q;
	logic              scl_oe_q;
	logic              sda_oe_q;
	logic              rx_valid_q;
	logic [BYTE_W-1:0] rx_data_q;
	logic              t2_reload_q;
	logic              t2_count_q;
	logic [7:0]        hold_cnt;
	logic [7:0]        ready_cnt;
	logic              drive_low;
	logic              fifo_valid;
	logic              fifo_pop;
	logic [BYTE_W-1:0] fifo_data;

	////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// bus idles high, so sync flops reset to one
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], SCL_I};
			sda_sync_q <= {sda_sync_q[0], SDA_I};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end
	assign scl_s      = scl_sync_q[1];
	assign sda_s      = sda_sync_q[1];
	assign scl_fall   = scl_prev_q && !scl_s;
	assign start_seen = scl_prev_q && scl_s && sda_prev_q && !sda_s;
	assign stop_seen  = scl_prev_q && scl_s && !sda_prev_q && sda_s;

	////////////////////////////////////////////////////////////////////////////
	// bit-clock tick and sda timing

	always_comb begin
		case (CFG_I.bit_clock_select) // R14
			SEL_TIMER0:    sel_ovf = TICK_I.timer0_ovf;
			SEL_TIMER1:    sel_ovf = TICK_I.timer1_ovf;
			SEL_TIMER2_HI: sel_ovf = TICK_I.timer2_hi_ovf;
			SEL_TIMER2_LO: sel_ovf = TICK_I.timer2_lo_ovf;
			default:       sel_ovf = 1'b0;
		endcase
	end
	assign tick = sel_ovf && (master_q || CFG_I.bus_free_timeout_en); // R15

	assign hold_cnt  = CFG_I.sda_timing_extension ? HOLD_EXT : HOLD_STD; // R19 R20
	assign ready_cnt = hold_cnt + (CFG_I.sda_timing_extension ? SETUP_EXT : SETUP_STD); // R19 R20

	// level to put on sda for the current bit
	always_comb begin
		drive_low = 1'b0;
		if (state_q == ST_SLAVE) begin
			drive_low = (bit_q == BIT_ACK) && !ignore_q && !blocked_q && !irq_q && ack_q; // R12
		end else if (tx_mode_q && bit_q != BIT_ACK) begin
			drive_low = !shift_q[BYTE_W-1];
		end else if (!tx_mode_q && bit_q == BIT_ACK) begin
			drive_low = ack_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus-free timeout and busy tracking

	assign free_ev = tick && scl_s && sda_s && busy_q && (free_cnt_q == FREE_TICKS)
		&& CFG_I.bus_free_timeout_en; // R5

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			free_cnt_q <= 4'h0;
		end else if (!CFG_I.bus_free_timeout_en || !scl_s || !sda_s) begin
			free_cnt_q <= 4'h0;
		end else if (tick && free_cnt_q <= FREE_TICKS) begin
			free_cnt_q <= free_cnt_q + 4'h1; // R5
		end
	end

	// busy clears on stop or free timeout, which frees a pending start
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else if (!CFG_I.interface_enable_bit) begin
			busy_q <= 1'b0;
		end else if (start_seen) begin
			busy_q <= 1'b1;
		end else if (stop_seen || free_ev) begin
			busy_q <= 1'b0; // R6
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scl low timeout support: timer 2 gating

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			t2_reload_q <= 1'b0;
			t2_count_q  <= 1'b0;
		end else begin
			t2_reload_q <= CFG_I.interface_enable_bit && CFG_I.scl_low_timeout_en && scl_s; // R2 R4
			t2_count_q  <= CFG_I.interface_enable_bit && CFG_I.scl_low_timeout_en && !scl_s; // R2 R4
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit fifo; the byte engine drains it only between bytes

	assign fifo_pop = (state_q == ST_STALL) && !irq_q && !halt_q && tx_mode_q && master_q
		&& (bit_q == BIT_ACK);

	smbus_tx_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i       (CLK_I),
		.rst_n_i     (rst_n),
		.in_valid_i  (TX_VALID_I),
		.in_ready_o  (TX_READY_O),
		.in_data_i   (TX_DATA_I),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// byte engine, scl generation and flags

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= ST_IDLE;
			bit_q      <= BIT_ACK;
			shift_q    <= 8'h00;
			clk_cnt_q  <= 8'h00;
			tick_cnt_q <= 2'h0;
			sampled_q  <= 1'b0;
			master_q   <= 1'b0;
			tx_mode_q  <= 1'b0;
			addr_q     <= 1'b0;
			rw_q       <= 1'b0;
			blocked_q  <= 1'b0;
			ignore_q   <= 1'b0;
			ack_q      <= 1'b0;
			irq_q      <= 1'b0;
			halt_q     <= 1'b0;
			arb_q      <= 1'b0;
			ack_rx_q   <= 1'b0;
			scl_oe_q   <= 1'b0;
			rx_valid_q <= 1'b0;
			rx_data_q  <= 8'h00;
		end else if (!CFG_I.interface_enable_bit) begin
			state_q    <= ST_IDLE; // R11 R24
			bit_q      <= BIT_ACK;
			master_q   <= 1'b0;
			tx_mode_q  <= 1'b0;
			irq_q      <= 1'b0;
			halt_q     <= 1'b0;
			arb_q      <= 1'b0;
			scl_oe_q   <= 1'b0; // R24
			rx_valid_q <= 1'b0;
		end else begin
			rx_valid_q <= 1'b0;
			clk_cnt_q  <= scl_fall ? 8'h00 : (clk_cnt_q == CNT_MAX ? CNT_MAX : clk_cnt_q + 8'h01);
			// software clear; any set below in the same cycle wins
			if (INT_CLEAR_I) begin
				irq_q <= 1'b0;
				arb_q <= 1'b0;
				ack_q <= ACK_VALUE_I; // R21
				if (!master_q) begin
					halt_q <= 1'b0;
				end
			end
			if (STOP_REQ_I && master_q) begin
				halt_q <= 1'b1;
			end
			if (free_ev) begin
				irq_q  <= 1'b1; // R7
				halt_q <= 1'b1; // R7
			end
			case (state_q)
				ST_IDLE: begin
					scl_oe_q <= 1'b0;
					if (start_seen) begin
						state_q   <= ST_SLAVE;
						bit_q     <= BIT_FIRST;
						addr_q    <= 1'b1;
						blocked_q <= CFG_I.slave_events_block; // R13
						ignore_q  <= 1'b0;
					end else if (START_REQ_I && !busy_q && !free_ev) begin
						state_q    <= ST_START; // R6
						master_q   <= 1'b1;
						tick_cnt_q <= 2'h0;
					end
				end
				ST_START: begin
					if (tick) begin
						scl_oe_q  <= 1'b1;
						tx_mode_q <= 1'b1;
						addr_q    <= 1'b1;
						bit_q     <= BIT_ACK;
						irq_q     <= 1'b1; // R10
						state_q   <= ST_STALL;
					end
				end
				ST_STALL: begin
					scl_oe_q <= 1'b1; // R23
					if (!irq_q) begin
						clk_cnt_q  <= 8'h00;
						tick_cnt_q <= 2'h0;
						if (!tx_mode_q && bit_q == BIT_LAST) begin
							bit_q   <= BIT_ACK;
							state_q <= ST_LOW;
						end else if (halt_q) begin
							state_q <= ST_STOP_LOW;
						end else if (!tx_mode_q) begin
							bit_q   <= BIT_FIRST;
							state_q <= ST_LOW;
						end else if (fifo_valid) begin
							shift_q <= fifo_data;
							bit_q   <= BIT_FIRST;
							state_q <= ST_LOW;
							if (addr_q) begin
								rw_q <= fifo_data[0];
							end
						end
					end
				end
				ST_LOW: begin
					scl_oe_q <= 1'b1;
					if (tick && tick_cnt_q != TICKS_LOW) begin
						tick_cnt_q <= tick_cnt_q + 2'h1;
					end
					if (tick_cnt_q == TICKS_LOW && clk_cnt_q >= ready_cnt) begin
						scl_oe_q   <= 1'b0; // R16 R19 R20
						tick_cnt_q <= 2'h0;
						sampled_q  <= 1'b0;
						state_q    <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					// no tick counts until scl is really high, so a stretching slave sets the pace
					if (scl_s && !sampled_q) begin
						sampled_q <= 1'b1; // R1
						if (bit_q == BIT_ACK) begin
							ack_rx_q <= !sda_s;
						end else begin
							shift_q <= {shift_q[BYTE_W-2:0], sda_s};
						end
						if (tx_mode_q && bit_q != BIT_ACK && shift_q[BYTE_W-1] && !sda_s) begin
							arb_q    <= 1'b1;
							irq_q    <= 1'b1;
							master_q <= 1'b0;
							addr_q   <= 1'b0;
							state_q  <= ST_SLAVE;
						end
					end else if (scl_s && tick) begin
						tick_cnt_q <= tick_cnt_q + 2'h1;
						if (tick_cnt_q + 2'h1 == TICKS_HIGH) begin
							scl_oe_q   <= 1'b1; // R16 R17
							clk_cnt_q  <= 8'h00;
							tick_cnt_q <= 2'h0;
							if (bit_q == BIT_ACK && tx_mode_q) begin
								irq_q   <= 1'b1; // R9
								state_q <= ST_STALL;
								if (addr_q) begin
									addr_q    <= 1'b0;
									tx_mode_q <= !rw_q;
								end
							end else if (bit_q == BIT_ACK) begin
								bit_q   <= BIT_FIRST;
								state_q <= halt_q ? ST_STOP_LOW : ST_LOW;
							end else if (bit_q == BIT_LAST && !tx_mode_q) begin
								irq_q      <= 1'b1; // R9
								rx_valid_q <= 1'b1;
								rx_data_q  <= shift_q;
								state_q    <= ST_STALL;
							end else begin
								bit_q   <= bit_q + 4'h1;
								state_q <= ST_LOW;
							end
						end
					end
				end
				ST_STOP_LOW: begin
					scl_oe_q <= 1'b1;
					if (tick && tick_cnt_q != TICKS_LOW) begin
						tick_cnt_q <= tick_cnt_q + 2'h1;
					end
					if (tick_cnt_q == TICKS_LOW && clk_cnt_q >= ready_cnt) begin
						scl_oe_q   <= 1'b0;
						tick_cnt_q <= 2'h0;
						state_q    <= ST_STOP_HIGH;
					end
				end
				ST_STOP_HIGH: begin
					if (scl_s && tick) begin
						halt_q    <= 1'b0;
						master_q  <= 1'b0;
						tx_mode_q <= 1'b0;
						state_q   <= ST_IDLE;
					end
				end
				ST_SLAVE: begin
					// hold scl low only while our own byte flag is pending
					scl_oe_q <= irq_q && bit_q == BIT_ACK && !ignore_q && !blocked_q; // R23 R12
					if (start_seen) begin
						bit_q     <= BIT_FIRST;
						addr_q    <= 1'b1;
						blocked_q <= CFG_I.slave_events_block; // R13
						ignore_q  <= 1'b0;
					end else if (stop_seen) begin
						state_q  <= ST_IDLE;
						scl_oe_q <= 1'b0;
						if (!blocked_q && !ignore_q) begin
							irq_q  <= 1'b1; // R10
							halt_q <= 1'b1;
						end
					end else if (free_ev) begin
						state_q  <= ST_IDLE; // R7
						scl_oe_q <= 1'b0;
					end else if (scl_prev_q == 1'b0 && scl_s && bit_q != BIT_ACK) begin
						shift_q <= {shift_q[BYTE_W-2:0], sda_s};
					end else if (scl_fall) begin
						if (bit_q == BIT_ACK) begin
							bit_q  <= BIT_FIRST;
							addr_q <= 1'b0;
							if (addr_q && !ack_q) begin
								ignore_q <= 1'b1;
							end
						end else begin
							bit_q <= bit_q + 4'h1;
							if (bit_q == BIT_LAST && !blocked_q && !ignore_q) begin
								irq_q      <= 1'b1; // R9 R12
								rx_valid_q <= 1'b1;
								rx_data_q  <= shift_q;
							end
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// in the low, slave and stop-low states sda changes only once the hold time after scl fell has passed
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_q <= 1'b0;
		end else if (!CFG_I.interface_enable_bit) begin
			sda_oe_q <= 1'b0; // R24
		end else begin
			case (state_q)
				ST_IDLE:      sda_oe_q <= 1'b0;
				ST_START:     sda_oe_q <= 1'b1;
				ST_STOP_LOW:  sda_oe_q <= (clk_cnt_q >= hold_cnt) ? 1'b1 : sda_oe_q;
				ST_LOW:       sda_oe_q <= (clk_cnt_q >= hold_cnt) ? drive_low : sda_oe_q; // R19 R20
				ST_SLAVE:     sda_oe_q <= (clk_cnt_q >= hold_cnt) ? drive_low : sda_oe_q; // R19 R20
				default:      sda_oe_q <= sda_oe_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign SCL_O           = 1'b0;
	assign SDA_O           = 1'b0;
	assign SCL_OE_O        = scl_oe_q;
	assign SDA_OE_O        = sda_oe_q;
	assign IRQ_FLAG_O      = irq_q;
	assign RX_VALID_O      = rx_valid_q;
	assign RX_DATA_O       = rx_data_q;
	assign TIMER2_RELOAD_O = t2_reload_q;
	assign TIMER2_COUNT_O  = t2_count_q;
	assign STATUS_O        = '{master: master_q, tx_mode: tx_mode_q, busy: busy_q,
		halt_condition_flag: halt_q, arb_lost: arb_q, ack_received: ack_rx_q};

endmodule

// File: smbus_timing_pkg.sv
// shared constants and types for the two-wire serial timing block
package smbus_timing_pkg;

	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned FIFO_DEPTH = 16;

	// bit positions within a byte frame
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BIT_ACK   = 4'h8;

	// sda hold and setup in core_clock cycles
	localparam logic [7:0] HOLD_STD  = 8'h03;
	localparam logic [7:0] HOLD_EXT  = 8'h0C;
	localparam logic [7:0] SETUP_STD = 8'h01;
	localparam logic [7:0] SETUP_EXT = 8'h0B;
	localparam logic [7:0] CNT_MAX   = 8'hFF;

	// scl phase lengths in bit-clock ticks; high is twice low
	localparam logic [1:0] TICKS_LOW  = 2'h1;
	localparam logic [1:0] TICKS_HIGH = 2'h2;

	// bus free after more than this many ticks of idle-high
	localparam logic [3:0] FREE_TICKS = 4'hA;

	// bit_clock_select encodings
	localparam logic [1:0] SEL_TIMER0    = 2'h0;
	localparam logic [1:0] SEL_TIMER1    = 2'h1;
	localparam logic [1:0] SEL_TIMER2_HI = 2'h2;
	localparam logic [1:0] SEL_TIMER2_LO = 2'h3;

	typedef struct packed {
		logic       interface_enable_bit;
		logic       slave_events_block;
		logic       sda_timing_extension;
		logic       scl_low_timeout_en;
		logic       bus_free_timeout_en;
		logic [1:0] bit_clock_select;
	} cfg_type;

	typedef struct packed {
		logic timer0_ovf;
		logic timer1_ovf;
		logic timer2_hi_ovf;
		logic timer2_lo_ovf;
	} tick_type;

	typedef struct packed {
		logic master;
		logic tx_mode;
		logic busy;
		logic halt_condition_flag;
		logic arb_lost;
		logic ack_received;
	} status_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_STALL,
		ST_LOW,
		ST_HIGH,
		ST_STOP_LOW,
		ST_STOP_HIGH,
		ST_SLAVE
	} state_type;

endpackage

// File: smbus_timing_monitor.sv
// concurrent checks on the ports of the serial timing block
`timescale 1ns/1ps
module smbus_timing_monitor
	import smbus_timing_pkg::*;
(
	// clock, reset and controls
	input  wire logic       CLK_I,
	input  wire logic       RESET_N_I,
	input  wire cfg_type    CFG_I,
	input  wire logic       INT_CLEAR_I,
	input  wire logic       SCL_I,
	// watched outputs
	input  wire logic       IRQ_FLAG_O,
	input  wire status_type STATUS_O,
	input  wire logic       TIMER2_RELOAD_O,
	input  wire logic       TIMER2_COUNT_O,
	input  wire logic       SCL_OE_O,
	input  wire logic       SDA_OE_O
);
	logic       tmr_en;
	logic       sda_prev_q;
	logic [3:0] age_q;
	assign tmr_en = CFG_I.interface_enable_bit & CFG_I.scl_low_timeout_en;
	// cycles since sda last moved, saturating so it never wraps
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sda_prev_q <= 1'b0;
			age_q      <= 4'h0;
		end else begin
			sda_prev_q <= SDA_OE_O;
			if (SDA_OE_O != sda_prev_q)
				age_q <= 4'h0;
			else if (age_q != 4'hF)
				age_q <= age_q + 4'h1;
		end
	end
////////////////////////////////////////
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence own_fall;
		$rose(SCL_OE_O) && STATUS_O.master;
	endsequence
	sequence hold_long;
		$stable(SDA_OE_O)[*8] ##1 $stable(SDA_OE_O)[*2];
	endsequence
	// six cycles cover the three-cycle pin latency plus margin
	a_timer_reload: assert property ((tmr_en && SCL_I)[*6] |-> TIMER2_RELOAD_O && !TIMER2_COUNT_O)
		else $error("timer reload missing while scl high");
	a_timer_count: assert property ((tmr_en && !SCL_I)[*6] |-> TIMER2_COUNT_O && !TIMER2_RELOAD_O)
		else $error("timer count missing while scl low");
	a_timer_idle: assert property ((!tmr_en)[*4] |-> !TIMER2_COUNT_O && !TIMER2_RELOAD_O)
		else $error("timer control active while disabled");
	a_disable_release: assert property ((!CFG_I.interface_enable_bit)[*3] |->
		!SCL_OE_O && !SDA_OE_O && !IRQ_FLAG_O && !STATUS_O.busy)
		else $error("bus not released when disabled");
	a_irq_stall: assert property ($rose(IRQ_FLAG_O) && STATUS_O.master ##1 IRQ_FLAG_O |-> SCL_OE_O)
		else $error("scl not held low while flag set");
	a_irq_holds: assert property (IRQ_FLAG_O && !INT_CLEAR_I && CFG_I.interface_enable_bit |=> IRQ_FLAG_O)
		else $error("flag dropped without clear");
	a_hold_ext: assert property (own_fall ##0 CFG_I.sda_timing_extension |=> hold_long)
		else $error("sda hold too short with extension");
	a_hold_std: assert property (own_fall ##0 !CFG_I.sda_timing_extension |=> $stable(SDA_OE_O)[*2])
		else $error("sda hold too short");
	a_setup_ext: assert property ($fell(SCL_OE_O) && STATUS_O.master && CFG_I.interface_enable_bit
		&& CFG_I.sda_timing_extension |-> age_q >= 4'h8)
		else $error("sda setup too short with extension");
endmodule
bind smbus_timing_ctrl smbus_timing_monitor u_mon (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CFG_I(CFG_I),
	.INT_CLEAR_I(INT_CLEAR_I), .SCL_I(SCL_I), .IRQ_FLAG_O(IRQ_FLAG_O), .STATUS_O(STATUS_O),
	.TIMER2_RELOAD_O(TIMER2_RELOAD_O), .TIMER2_COUNT_O(TIMER2_COUNT_O), .SCL_OE_O(SCL_OE_O), .SDA_OE_O(SDA_OE_O));

// File: smbus_peer_model.sv
// far-side slave: acknowledges every byte and can stretch scl once
`timescale 1ns/1ps
module smbus_peer_model (
	input  wire logic clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic stretch_i,
	output logic      scl_oe_o,
	output logic      sda_oe_o
);
	logic       scl_q = 1'b1;
	logic       sda_q = 1'b1;
	logic       ack_q = 1'b0;
	logic       done_q = 1'b0;
	logic [3:0] cnt_q = 4'h0;
	logic [5:0] hold_q = 6'h00;
	assign scl_oe_o = hold_q != 6'h00;
	assign sda_oe_o = ack_q;
	always @(posedge clk_i) begin
		scl_q <= scl_i;
		sda_q <= sda_i;
		if (scl_i && scl_q && sda_q && !sda_i) begin
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
		end else if (scl_q && !scl_i) begin
			cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
			ack_q <= cnt_q == 4'h8;
		end
		// one long stretch per request, to test a slow device
		if (scl_q && !scl_i && stretch_i && !done_q) begin
			hold_q <= 6'h32;
			done_q <= 1'b1;
		end else if (hold_q != 6'h00)
			hold_q <= hold_q - 6'h01;
		if (!stretch_i)
			done_q <= 1'b0;
	end
endmodule

// File: tb_smbus_timing_ctrl.sv
// self-checking bench for the serial timing block
`timescale 1ns/1ps
module tb_smbus_timing_ctrl
	import smbus_timing_pkg::*;
;
	logic       clk = 1'b0, rst_n = 1'b0, start_req = 1'b0, stop_req = 1'b0, int_clr = 1'b0;
	logic       tx_valid = 1'b0, tx_ready, rx_valid, irq, t2r, t2c, scl_oe, sda_oe;
	logic       p_scl, p_sda, t_scl = 1'b0, t_sda = 1'b0, stretch = 1'b0, tk_on = 1'b1, sp = 1'b1;
	logic [7:0] tx_data = 8'h00, rx_data, b;
	logic [3:0] tmask = 4'h8, w;
	logic [2:0] cyc = 3'h0;
	logic [8:0] capt = 9'h000;
	cfg_type    cfg = 7'h00;
	tick_type   tick = 4'h0;
	status_type sts;
	int         n_errors = 0, n_tests = 0, k, i, run = 0, lomin = 999, himin = 999;
	wire        scl = !(scl_oe | p_scl | t_scl);
	wire        sda = !(sda_oe | p_sda | t_sda);
	assign w = {sda_oe, tx_ready, sts.master, irq};
	smbus_timing_ctrl smbus_timing_ctrl_inst (.CLK_I(clk), .RESET_N_I(rst_n), .CFG_I(cfg), .TICK_I(tick),
		.START_REQ_I(start_req), .STOP_REQ_I(stop_req), .INT_CLEAR_I(int_clr), .ACK_VALUE_I(1'b0),
		.TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .TX_DATA_I(tx_data), .RX_VALID_O(rx_valid),
		.RX_DATA_O(rx_data), .IRQ_FLAG_O(irq), .STATUS_O(sts), .TIMER2_RELOAD_O(t2r), .TIMER2_COUNT_O(t2c),
		.SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe));
	smbus_peer_model smbus_peer_model_inst (.clk_i(clk), .scl_i(scl), .sda_i(sda), .stretch_i(stretch),
		.scl_oe_o(p_scl), .sda_oe_o(p_sda));
	always #25 clk = !clk;
	// free-running tick every 8 clocks; wire bits and phase lengths
	always @(posedge clk) begin
		cyc <= cyc + 3'h1;
		if (tk_on)
			tick <= (cyc == 3'h7) ? tmask : 4'h0;
		sp <= scl;
		if (scl && !sp)
			capt <= {capt[7:0], sda};
		if (scl == sp)
			run <= run + 1;
		else begin
			run <= 1;
			if (sp && run < himin)
				himin <= run;
			if (!sp && run < lomin)
				lomin <= run;
		end
	end
////////////////////////////////////////
	task automatic results;
		$display("n_errors=%0d n_tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({8'h00, got}, {8'h00, exp});
	endtask
	task automatic wfor(input int s, input logic v);
		int t;
		for (t = 0; t < 8000 && w[s] !== v; t++)
			@(posedge clk);
		if (w[s] !== v) begin
			n_errors++;
			$display("Error at %0t: wait timed out", $time);
			results;
		end
	endtask
	task automatic pulse(input int s);
		@(posedge clk) {stop_req, int_clr} <= (s == 0) ? 2'h1 : 2'h2;
		@(posedge clk) {stop_req, int_clr} <= 2'h0;
	endtask
	task automatic tickp;
		@(posedge clk) tick <= 4'h8;
		@(posedge clk) tick <= 4'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic xfer(input int n);
		for (b = 8'hA0; b < 8'hA0 + n; b++) begin
			tx_valid <= 1'b1;
			tx_data  <= b;
			@(posedge clk);
			wfor(2, 1'b1);
		end
		// stop pushing, else stale bytes pile up; a full fifo drops ready
		tx_valid  <= 1'b0;
		repeat (3) @(posedge clk);
		if (n == 16)
			chkb(tx_ready, 1'b0);
		start_req <= 1'b1;
		if (n == 16) begin
			wfor(3, 1'b1);
			repeat (100) @(posedge clk);
			chkb(scl_oe, 1'b0);
			tmask <= 4'h8;
		end
		wfor(0, 1'b1);
		start_req <= 1'b0;
		chkb(sts.master, 1'b1);
		repeat (4) @(posedge clk);
		chk({7'h00, t2r, t2c}, 9'h001);
		for (b = 8'hA0; b < 8'hA0 + n; b++) begin
			pulse(0);
			wfor(0, 1'b0);
			wfor(0, 1'b1);
			chk(capt, {b, 1'b0});
			chkb(sts.ack_received, 1'b1);
		end
		pulse(1);
		pulse(0);
		wfor(1, 1'b0);
		chk({7'h00, sts.halt_condition_flag, tx_ready}, 9'h001);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		for (k = 0; k < 4; k++) begin
			cfg     <= {1'b1, 1'b0, k[0], 1'b1, 1'b0, k[1:0]};
			tmask   <= (k == 0) ? 4'h4 : 4'h8 >> k;
			stretch <= k == 0;
			@(posedge clk);
			xfer((k == 0) ? 16 : 2);
		end
		chkb(himin >= 8, 1'b1);
		chkb(lomin >= 4, 1'b1);
		// foreign start leaves the bus busy, then ticks are counted by hand
		tk_on <= 1'b0;
		cfg   <= {1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0};
		tick  <= 4'h0;
		@(posedge clk) t_sda <= 1'b1;
		repeat (4) @(posedge clk) t_scl <= 1'b1;
		repeat (4) @(posedge clk) t_sda <= 1'b0;
		repeat (4) @(posedge clk) t_scl <= 1'b0;
		start_req <= 1'b1;
		repeat (5) @(posedge clk);
		chk({7'h00, sts.busy, sda_oe}, 9'h002);
		for (i = 0; i < 10; i++)
			tickp;
		chkb(irq, 1'b0);
		tickp;
		chk({7'h00, irq, sts.halt_condition_flag}, 9'h003);
		wfor(3, 1'b1);
		tk_on <= 1'b1;
		wfor(0, 1'b1);
		cfg.interface_enable_bit <= 1'b0;
		repeat (3) @(posedge clk);
		chk({5'h00, scl_oe, sda_oe, irq, sts.master}, 9'h000);
		repeat (100) @(posedge clk);
		chkb(sda_oe, 1'b0);
		results;
	end
endmodule
